// file: core/usrx_top.sv
// Receive path of a serial port: pin sampling, frame recovery, two-entry FIFO and APB registers.
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Setting receiver enable gives the serial input pin to the receiver.
// - Synchronous mode clocks bits on the external transfer clock pin.
// - A frame starts only on a valid start bit; bits shift in.
// - A second stop bit is ignored; only the first is examined.
// - After the first stop bit the frame moves into the receive buffer.
// - Unused upper data bits read as zero for short characters.
// - Ninth bit and error flags travel with their frame; data read advances.
// - Receive complete is one exactly while the buffer holds unread data.
// - Clearing receiver enable flushes the buffer and clears receive complete.
// - Interrupt request is a level while enabled, flag set, global enable.
// - Status writes never alter frame, overrun or parity error flags.
// - Error flags never raise an interrupt request.
// - Frame error shows the first stop bit of the next readable frame.
// - Overrun when buffer full, frame waiting, and new start bit found.
// - Overrun clears when a frame is moved into the buffer.
// - Parity error reads zero while parity checking is off.
// - Parity checker compares data parity of chosen type with parity bit.
// - Parity error needs a mismatch and checking on at reception.
// - Disabling stops at once, drops the frame, releases the pin.
// - Asynchronous sampling runs at 16x, or 8x in double speed.
// - Each asynchronous bit is a two-of-three vote over the centre samples; synchronous bits take one sample.
// - A start bit with two or more high centre samples is noise.
module usrx_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire usrx_pkg::usrx_apb_req_t apb_req,
  output var usrx_pkg::usrx_apb_rsp_t apb_rsp,
  input wire logic rxd_pin,
  input wire logic xck_pin,
  input wire logic global_irq_enable,
  output logic rx_irq,
  output logic rx_pin_override
);
  import usrx_pkg::*;

  usrx_state_t s_q;
  usrx_state_t s_d;
  logic rx;
  logic tick;
  logic xck_rise;
  logic [4:0] spb;
  logic [4:0] sf;
  logic [4:0] cnt_n;
  logic [2:0] vote3;
  logic maj;
  logic [3:0] nbits;
  logic [3:0] last_idx;
  logic bit_ev;
  logic bit_val;
  logic start_det;
  logic frame_done;
  usrx_entry_t new_ent;
  usrx_entry_t head;
  logic rxc;
  logic setup;
  logic access;
  logic pop;
  logic rd_new;
  logic [1:0] avail;
  logic [31:0] rdata;
  logic unmapped;

  // Next-state logic for the whole block; every register lives in s_q.
  always_comb begin
    s_d = s_q;
    tick = 1'b0;
    bit_ev = 1'b0;
    bit_val = 1'b0;
    start_det = 1'b0;
    frame_done = 1'b0;
    new_ent = '0;
    pop = 1'b0;
    rdata = '0;
    unmapped = 1'b0;

    // Pin inputs pass two flops; edge detection looks only at the second stage.
    s_d.rx_s1 = rxd_pin;
    s_d.rx_s2 = s_q.rx_s1;
    s_d.xk_s1 = xck_pin;
    s_d.xk_s2 = s_q.xk_s1;
    s_d.xk_prev = s_q.xk_s2;
    rx = s_q.rx_s2;
    xck_rise = s_q.xk_s2 & ~s_q.xk_prev;

    // Sample-rate tick: one tick every baud+1 clocks.
    if (s_q.baud_cnt == '0) begin
      tick = 1'b1;
      s_d.baud_cnt = s_q.baud;
    end else begin
      s_d.baud_cnt = s_q.baud_cnt - 12'h001;
    end

    // Frame geometry from the current configuration.
    spb = s_q.dbl ? USRX_SPB_DOUBLE : USRX_SPB_NORMAL;
    sf = s_q.dbl ? USRX_SF_DOUBLE : USRX_SF_NORMAL;
    cnt_n = (s_q.cnt == spb) ? USRX_SAMPLE_ONE : s_q.cnt + USRX_SAMPLE_ONE;
    vote3 = {s_q.vote, rx};
    maj = (vote3[0] & vote3[1]) | (vote3[0] & vote3[2]) | (vote3[1] & vote3[2]);
    nbits = (s_q.cs == USRX_CS_NINE) ? USRX_BITS_NINE : {2'b00, s_q.cs[1:0]} + USRX_BITS_MIN;
    // Stop index counts only the first stop bit, whatever the stop setting.
    last_idx = nbits + {3'b000, s_q.par_en};

    // Receiver sequencing; runs only while enabled.
    if (s_q.rxen) begin
      unique case (s_q.phase)
        USRX_IDLE: begin
          if (s_q.sync_mode) begin
            if (xck_rise && !rx) begin
              start_det = 1'b1;
              s_d.phase = USRX_BITS;
              s_d.idx = '0;
              s_d.shreg = '0;
            end
          end else if (tick) begin
            s_d.armed = rx;
            // A start needs a high-to-low transition between two ticks.
            if (s_q.armed && !rx) begin
              s_d.phase = USRX_START;
              s_d.cnt = USRX_SAMPLE_ONE;
            end
          end
        end
        USRX_START: begin
          if (tick) begin
            s_d.cnt = cnt_n;
            if (cnt_n == sf || cnt_n == sf + USRX_SAMPLE_ONE) begin
              s_d.vote = {s_q.vote[0], rx};
            end
            if (cnt_n == sf + USRX_VOTE_SPAN) begin
              if (maj) begin
                s_d.phase = USRX_IDLE;
                s_d.armed = 1'b1;
              end else begin
                start_det = 1'b1;
                s_d.phase = USRX_BITS;
                s_d.idx = '0;
                s_d.shreg = '0;
              end
            end
          end
        end
        USRX_BITS: begin
          if (s_q.sync_mode) begin
            bit_ev = xck_rise;
            bit_val = rx;
          end else if (tick) begin
            s_d.cnt = cnt_n;
            if (cnt_n == sf || cnt_n == sf + USRX_SAMPLE_ONE) begin
              s_d.vote = {s_q.vote[0], rx};
            end
            bit_ev = (cnt_n == sf + USRX_VOTE_SPAN);
            bit_val = maj;
          end
        end
        default: begin
          s_d.phase = USRX_IDLE;
        end
      endcase
    end

    // Bit placement: data bits by index, then parity, then the first stop bit.
    if (bit_ev) begin
      s_d.idx = s_q.idx + 4'h1;
      if (s_q.idx < nbits) begin
        s_d.shreg[s_q.idx] = bit_val;
      end else if (s_q.idx != last_idx) begin
        s_d.pbit = bit_val;
      end else begin
        // The frame ends right after the stop vote so an early next start is caught.
        frame_done = 1'b1;
        s_d.phase = USRX_IDLE;
        s_d.armed = bit_val;
        new_ent.data = s_q.shreg;
        new_ent.fe = ~bit_val;
        new_ent.upe = s_q.par_en & ((^s_q.shreg ^ s_q.pbit) != s_q.par_odd);
      end
    end

    // A new start while the buffer is full and a frame waits loses the waiting frame.
    if (start_det && s_q.hold) begin
      s_d.hold = 1'b0;
      s_d.dor_pend = 1'b1;
    end

    // APB decode: answer in the cycle after setup, zero wait states.
    setup = apb_req.psel & ~apb_req.penable;
    access = apb_req.psel & apb_req.penable & s_q.rsp.pready;
    head = s_q.fifo[s_q.rd_ptr];
    rxc = (s_q.count != 2'b00);
    unique case (apb_req.paddr)
      USRX_OFS_STATUS_A: begin
        rdata[USRX_STA_RXC] = rxc;
        rdata[USRX_STA_FE] = rxc & head.fe;
        rdata[USRX_STA_DOR] = rxc & head.dor;
        rdata[USRX_STA_UPE] = rxc & head.upe & s_q.par_en;
        rdata[USRX_STA_DBL] = s_q.dbl;
      end
      USRX_OFS_CONTROL_B: begin
        rdata[USRX_CTB_RXCIE] = s_q.rxcie;
        rdata[USRX_CTB_RXEN] = s_q.rxen;
        rdata[USRX_CTB_CS2] = s_q.cs[2];
        rdata[USRX_CTB_RXB8] = rxc & head.data[8];
      end
      USRX_OFS_CONTROL_C: begin
        rdata[USRX_CTC_SYNC] = s_q.sync_mode;
        rdata[USRX_CTC_PEN] = s_q.par_en;
        rdata[USRX_CTC_PODD] = s_q.par_odd;
        rdata[USRX_CTC_STOP2] = s_q.stop2;
        rdata[USRX_CTC_CS1] = s_q.cs[1];
        rdata[USRX_CTC_CS0] = s_q.cs[0];
      end
      USRX_OFS_DATA: begin
        rdata[7:0] = rxc ? head.data[7:0] : 8'h00;
      end
      USRX_OFS_BAUD: begin
        rdata[11:0] = s_q.baud;
      end
      default: begin
        unmapped = 1'b1;
      end
    endcase

    // Read data is captured in the setup cycle and held through the access cycle.
    s_d.rsp.pready = setup;
    if (setup) begin
      s_d.rsp.prdata = rdata;
      s_d.rsp.pslverr = unmapped;
      s_d.pop_ok = (apb_req.paddr == USRX_OFS_DATA) & ~apb_req.pwrite & rxc;
    end else if (!access) begin
      s_d.rsp.pslverr = 1'b0;
    end

    // Register writes take effect at the completing edge of the access phase.
    if (access && apb_req.pwrite && !s_q.rsp.pslverr) begin
      unique case (apb_req.paddr)
        USRX_OFS_STATUS_A: begin
          // Only the speed select is writable; buffered flags ignore writes.
          s_d.dbl = apb_req.pwdata[USRX_STA_DBL];
        end
        USRX_OFS_CONTROL_B: begin
          s_d.rxcie = apb_req.pwdata[USRX_CTB_RXCIE];
          s_d.rxen = apb_req.pwdata[USRX_CTB_RXEN];
          s_d.cs[2] = apb_req.pwdata[USRX_CTB_CS2];
        end
        USRX_OFS_CONTROL_C: begin
          s_d.sync_mode = apb_req.pwdata[USRX_CTC_SYNC];
          s_d.par_en = apb_req.pwdata[USRX_CTC_PEN];
          s_d.par_odd = apb_req.pwdata[USRX_CTC_PODD];
          s_d.stop2 = apb_req.pwdata[USRX_CTC_STOP2];
          s_d.cs[1] = apb_req.pwdata[USRX_CTC_CS1];
          s_d.cs[0] = apb_req.pwdata[USRX_CTC_CS0];
        end
        USRX_OFS_BAUD: begin
          s_d.baud = apb_req.pwdata[11:0];
        end
        default: begin
          s_d.baud = s_q.baud;
        end
      endcase
    end
    // A completed data read advances the buffer to the next entry.
    pop = access & ~apb_req.pwrite & s_q.pop_ok & rxc;

    // Buffer update: the pop frees a slot in the same cycle a push may use it.
    rd_new = s_q.rd_ptr ^ pop;
    avail = s_q.count - {1'b0, pop};
    s_d.rd_ptr = rd_new;
    s_d.count = avail;
    if (s_q.hold && !avail[1]) begin
      s_d.fifo[rd_new ^ avail[0]] = s_q.hold_ent;
      s_d.fifo[rd_new ^ avail[0]].dor = s_q.dor_pend;
      s_d.count = avail + 2'b01;
      s_d.hold = 1'b0;
      s_d.dor_pend = 1'b0;
    end else if (frame_done) begin
      if (!avail[1]) begin
        s_d.fifo[rd_new ^ avail[0]] = new_ent;
        s_d.fifo[rd_new ^ avail[0]].dor = s_q.dor_pend;
        s_d.count = avail + 2'b01;
        s_d.dor_pend = 1'b0;
      end else begin
        // Buffer full: the frame waits in hold_ent until a read frees a slot.
        s_d.hold = 1'b1;
        s_d.hold_ent = new_ent;
      end
    end

    // Disable acts at once: frame dropped, buffer flushed, pin released.
    if (!s_d.rxen) begin
      s_d.phase = USRX_IDLE;
      s_d.armed = 1'b0;
      s_d.count = 2'b00;
      s_d.hold = 1'b0;
      s_d.dor_pend = 1'b0;
    end

    // Level request from the next flag value; error flags play no part.
    s_d.irq = s_d.rxcie & (s_d.count != 2'b00) & global_irq_enable;
    s_d.pin_override = s_d.rxen;
  end

  // State register; all fields clear on reset, which leaves the receiver disabled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register.
  assign apb_rsp = s_q.rsp;
  assign rx_irq = s_q.irq;
  assign rx_pin_override = s_q.pin_override;
endmodule

`default_nettype wire

// file: shared/usrx_pkg.sv
// Package with register map, field positions, timing constants and types of the receive path.
package usrx_pkg;
  // Register byte offsets on the APB slave.
  localparam logic [11:0] USRX_OFS_STATUS_A = 12'h000;
  localparam logic [11:0] USRX_OFS_CONTROL_B = 12'h004;
  localparam logic [11:0] USRX_OFS_CONTROL_C = 12'h008;
  localparam logic [11:0] USRX_OFS_DATA = 12'h00c;
  localparam logic [11:0] USRX_OFS_BAUD = 12'h010;
  // Status register A fields.
  localparam int USRX_STA_RXC = 7;
  localparam int USRX_STA_FE = 4;
  localparam int USRX_STA_DOR = 3;
  localparam int USRX_STA_UPE = 2;
  localparam int USRX_STA_DBL = 1;
  // Control register B fields.
  localparam int USRX_CTB_RXCIE = 7;
  localparam int USRX_CTB_RXEN = 4;
  localparam int USRX_CTB_CS2 = 2;
  localparam int USRX_CTB_RXB8 = 1;
  // Control register C fields.
  localparam int USRX_CTC_SYNC = 6;
  localparam int USRX_CTC_PEN = 5;
  localparam int USRX_CTC_PODD = 4;
  localparam int USRX_CTC_STOP2 = 3;
  localparam int USRX_CTC_CS1 = 2;
  localparam int USRX_CTC_CS0 = 1;
  // Character size handling.
  localparam logic [2:0] USRX_CS_NINE = 3'h7;
  localparam logic [3:0] USRX_BITS_MIN = 4'h5;
  localparam logic [3:0] USRX_BITS_NINE = 4'h9;
  // Oversampling: samples per bit and first voting sample.
  localparam logic [4:0] USRX_SPB_NORMAL = 5'h10;
  localparam logic [4:0] USRX_SPB_DOUBLE = 5'h08;
  localparam logic [4:0] USRX_SF_NORMAL = 5'h08;
  localparam logic [4:0] USRX_SF_DOUBLE = 5'h04;
  localparam logic [4:0] USRX_SAMPLE_ONE = 5'h01;
  localparam logic [4:0] USRX_VOTE_SPAN = 5'h02;
  localparam logic [11:0] USRX_BAUD_RESET = 12'h000;

  typedef enum logic [1:0] {USRX_IDLE, USRX_START, USRX_BITS} usrx_phase_t;

  typedef struct packed {
    logic [8:0] data;
    logic fe;
    logic dor;
    logic upe;
  } usrx_entry_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } usrx_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } usrx_apb_rsp_t;

  typedef struct packed {
    logic rx_s1;
    logic rx_s2;
    logic xk_s1;
    logic xk_s2;
    logic xk_prev;
    logic [11:0] baud_cnt;
    logic [11:0] baud;
    logic dbl;
    logic rxen;
    logic rxcie;
    logic [2:0] cs;
    logic sync_mode;
    logic par_en;
    logic par_odd;
    logic stop2;
    usrx_phase_t phase;
    logic [4:0] cnt;
    logic [1:0] vote;
    logic [3:0] idx;
    logic [8:0] shreg;
    logic pbit;
    logic armed;
    usrx_entry_t [1:0] fifo;
    logic rd_ptr;
    logic [1:0] count;
    logic hold;
    usrx_entry_t hold_ent;
    logic dor_pend;
    logic pop_ok;
    usrx_apb_rsp_t rsp;
    logic irq;
    logic pin_override;
  } usrx_state_t;
endpackage

// file: verification/testbench.sv
// Self-checking bench of the receive path, fed by the transmitter model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import usrx_pkg::*;
  typedef struct packed {
    logic [2:0] cs;
    logic pen, podd, dbl, sync, stop2, pbad, sbad;
    logic [8:0] data, exp;
    logic fe, upe;
  } usrx_row_t;
  // Settings and character sent, beside the character and flags read back.
  usrx_row_t rows [5] = '{
    '{3'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 9'h1f5, 9'h015, 1'h0, 1'h0},
    '{3'h3, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 9'h0a5, 9'h0a5, 1'h0, 1'h0},
    '{3'h3, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 9'h03c, 9'h03c, 1'h0, 1'h1},
    '{3'h7, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 9'h1a6, 9'h1a6, 1'h1, 1'h0},
    '{3'h2, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 9'h0ff, 9'h07f, 1'h0, 1'h0}};
  logic [7:0] ovr_tx [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
  logic [7:0] ovr_rx [3] = '{8'h11, 8'h22, 8'h44};
  logic ovr_dor [3] = '{1'h0, 1'h0, 1'h1};
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic gie = 1'h1;
  logic go = 1'h0;
  logic [8:0] tx_data = 9'h0;
  logic [3:0] tx_bits = 4'h8;
  logic tx_pen = 1'h0, tx_podd = 1'h0, tx_pbad = 1'h0, tx_sbad = 1'h0, tx_sync = 1'h0;
  logic [7:0] tx_len = 8'h10;
  usrx_apb_req_t apb_req = '0;
  usrx_apb_rsp_t apb_rsp;
  logic rxd, external_transfer_clock_pin, busy, rx_irq, rx_pin_override, err;
  logic [31:0] rv;
  int fails = 0;
  int total_checks = 0;
  always #2.5 pclk = ~pclk;
  usrx_tx_model usrx_tx_model_i (.pclk(pclk), .go(go), .data(tx_data), .nbits(tx_bits),
    .par_en(tx_pen), .par_odd(tx_podd), .par_bad(tx_pbad), .stop_bad(tx_sbad),
    .sync_mode(tx_sync), .bit_len(tx_len), .rxd(rxd), .external_transfer_clock_pin(external_transfer_clock_pin), .busy(busy));
  usrx_top usrx_top_i (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .rxd_pin(rxd), .xck_pin(external_transfer_clock_pin), .global_irq_enable(gie), .rx_irq(rx_irq),
    .rx_pin_override(rx_pin_override));
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; the request holds until pready is seen at an edge.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    apb_req <= '{1'h1, 1'h0, wr, a, wd};
    @(posedge pclk);
    apb_req.penable <= 1'h1;
    // Sampled right after the edge, pready and prdata still show the values that edge saw.
    do begin
      @(posedge pclk);
      n++;
    end while (apb_rsp.pready !== 1'h1 && n < 20);
    if (apb_rsp.pready !== 1'h1) begin
      fails++;
      complete_run();
    end
    rv = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge pclk);
  endtask
  task automatic send(input logic [8:0] d, input logic wait_done);
    int n;
    n = 0;
    tx_data <= d;
    go <= 1'h1;
    @(posedge pclk);
    go <= 1'h0;
    @(posedge pclk);
    while (wait_done && busy && n < 1000) begin
      n++;
      @(posedge pclk);
    end
    repeat (8) @(posedge pclk);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    foreach (rows[i]) begin
      tx_bits <= (rows[i].cs == USRX_CS_NINE) ? USRX_BITS_NINE
        : USRX_BITS_MIN + {2'h0, rows[i].cs[1:0]};
      {tx_pen, tx_podd, tx_pbad} <= {rows[i].pen, rows[i].podd, rows[i].pbad};
      {tx_sbad, tx_sync} <= {rows[i].sbad, rows[i].sync};
      tx_len <= rows[i].dbl ? 8'h08 : 8'h10;
      xfer(1'h1, USRX_OFS_CONTROL_C, {25'h0, rows[i].sync, rows[i].pen, rows[i].podd,
        rows[i].stop2, rows[i].cs[1:0], 1'h0});
      xfer(1'h1, USRX_OFS_STATUS_A, {30'h0, rows[i].dbl, 1'h0});
      xfer(1'h1, USRX_OFS_CONTROL_B, {24'h0, 1'h1, 2'h0, 1'h1, 1'h0, rows[i].cs[2], 2'h0});
      chk("pin override", 32'h1, rx_pin_override);
      send(rows[i].data, 1'h1);
      chk("irq", 32'h1, rx_irq);
      xfer(1'h0, USRX_OFS_STATUS_A, 32'h0);
      chk("complete flag", 32'h1, rv[USRX_STA_RXC]);
      chk("frame error", rows[i].fe, rv[USRX_STA_FE]);
      chk("parity error", rows[i].upe, rv[USRX_STA_UPE]);
      xfer(1'h0, USRX_OFS_CONTROL_B, 32'h0);
      chk("ninth bit", rows[i].exp[8], rv[USRX_CTB_RXB8]);
      xfer(1'h0, USRX_OFS_DATA, 32'h0);
      chk("data", rows[i].exp[7:0], rv[7:0]);
      xfer(1'h0, USRX_OFS_STATUS_A, 32'h0);
      chk("complete flag", 32'h0, rv[USRX_STA_RXC]);
    end
    // Four frames unread: two buffered, one waiting, the fourth start loses it.
    {tx_pen, tx_sync, tx_sbad, tx_bits, tx_len} <= {3'h0, 4'h8, 8'h10};
    xfer(1'h1, USRX_OFS_CONTROL_C, 32'h6);
    foreach (ovr_tx[i]) send({1'h0, ovr_tx[i]}, 1'h1);
    foreach (ovr_rx[i]) begin
      xfer(1'h0, USRX_OFS_STATUS_A, 32'h0);
      chk("overrun", ovr_dor[i], rv[USRX_STA_DOR]);
      xfer(1'h0, USRX_OFS_DATA, 32'h0);
      chk("data", ovr_rx[i], rv[7:0]);
    end
    xfer(1'h0, USRX_OFS_STATUS_A, 32'h0);
    chk("complete flag", 32'h0, rv[USRX_STA_RXC]);
    gie <= 1'h0;
    tx_sbad <= 1'h1;
    send(9'h05a, 1'h1);
    chk("masked irq", 32'h0, rx_irq);
    gie <= 1'h1;
    tx_sbad <= 1'h0;
    send(9'h0ff, 1'h0);
    chk("irq", 32'h1, rx_irq);
    repeat (40) @(posedge pclk);
    xfer(1'h1, USRX_OFS_CONTROL_B, 32'h0);
    chk("pin override", 32'h0, rx_pin_override);
    xfer(1'h0, USRX_OFS_STATUS_A, 32'h0);
    chk("complete flag", 32'h0, rv[USRX_STA_RXC]);
    xfer(1'h1, USRX_OFS_CONTROL_B, 32'h90);
    send(9'h0ff, 1'h1);
    xfer(1'h0, USRX_OFS_DATA, 32'h0);
    chk("abandoned frame", 32'h0, rv);
    xfer(1'h0, 12'h014, 32'h0);
    chk("slave error", 32'h1, err);
    complete_run();
  end
  // The run needs about 2000 cycles; this bound allows about ten times that.
  initial begin
    #100000;
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire

// file: verification/usrx_chk.sv
// Port checker for the receive path, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module usrx_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire usrx_pkg::usrx_apb_req_t apb_req,
  input wire usrx_pkg::usrx_apb_rsp_t apb_rsp,
  input wire logic rxd_pin,
  input wire logic xck_pin,
  input wire logic global_irq_enable,
  input wire logic rx_irq,
  input wire logic rx_pin_override
);
  import usrx_pkg::*;
  logic rd, wr, rxen_q, cie_q, par_q;
  logic [2:0] cs_q;
  logic [3:0] nbits;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // A transfer completes at the edge where the access phase meets pready.
  assign rd = apb_req.psel && apb_req.penable && apb_rsp.pready && !apb_req.pwrite;
  assign wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
  assign nbits = (cs_q == USRX_CS_NINE) ? USRX_BITS_NINE : USRX_BITS_MIN + {2'h0, cs_q[1:0]};
  // Shadow of the settings, so reads are judged against the live configuration.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxen_q <= 1'h0;
      cie_q <= 1'h0;
      par_q <= 1'h0;
      cs_q <= 3'h0;
    end else if (wr && apb_req.paddr == USRX_OFS_CONTROL_B) begin
      rxen_q <= apb_req.pwdata[USRX_CTB_RXEN];
      cie_q <= apb_req.pwdata[USRX_CTB_RXCIE];
      cs_q[2] <= apb_req.pwdata[USRX_CTB_CS2];
    end else if (wr && apb_req.paddr == USRX_OFS_CONTROL_C) begin
      par_q <= apb_req.pwdata[USRX_CTC_PEN];
      cs_q[1:0] <= apb_req.pwdata[USRX_CTC_CS1:USRX_CTC_CS0];
    end
  end
  a_pin_take: assert property (
    wr && apb_req.paddr == USRX_OFS_CONTROL_B
    |-> ##2 rx_pin_override == $past(apb_req.pwdata[USRX_CTB_RXEN], 2))
    else $error("pin override does not follow receiver enable");
  a_irq_gate: assert property (
    rx_irq |-> $past(global_irq_enable) || $past(global_irq_enable, 2))
    else $error("interrupt without global enable");
  a_irq_cie: assert property (
    rx_irq |-> cie_q || $past(cie_q))
    else $error("interrupt without its enable");
  a_irq_flush: assert property (
    !rx_pin_override [*2] |-> !rx_irq)
    else $error("interrupt while receiver disabled");
  a_flush_empty: assert property (
    rd && apb_req.paddr == USRX_OFS_STATUS_A && !rxen_q |-> !apb_rsp.prdata[USRX_STA_RXC])
    else $error("complete flag set while disabled");
  a_par_off: assert property (
    rd && apb_req.paddr == USRX_OFS_STATUS_A && !par_q |-> !apb_rsp.prdata[USRX_STA_UPE])
    else $error("parity error with checking off");
  a_short_zero: assert property (
    rd && apb_req.paddr == USRX_OFS_DATA |-> (apb_rsp.prdata >> nbits) == 32'h0)
    else $error("unused data bits not zero");
  a_irq_fall: assert property (
    $fell(rx_irq) |-> $past(rd) || $past(rd, 2) || $past(rd, 3) || !rxen_q || !cie_q
    || !$past(global_irq_enable) || !$past(global_irq_enable, 2))
    else $error("interrupt dropped without cause");
endmodule
bind usrx_top usrx_chk usrx_chk_i (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .rxd_pin(rxd_pin), .xck_pin(xck_pin), .global_irq_enable(global_irq_enable),
  .rx_irq(rx_irq), .rx_pin_override(rx_pin_override));
`default_nettype wire

// file: verification/usrx_tx_model.sv
// Behavioural remote transmitter that puts one frame per request on the receive line.
`timescale 1ns/1ps
`default_nettype none
module usrx_tx_model (
  input wire logic pclk,
  input wire logic go,
  input wire logic [8:0] data,
  input wire logic [3:0] nbits,
  input wire logic par_en,
  input wire logic par_odd,
  input wire logic par_bad,
  input wire logic stop_bad,
  input wire logic sync_mode,
  input wire logic [7:0] bit_len,
  output logic rxd,
  output logic external_transfer_clock_pin,
  output logic busy
);
  logic [11:0] frame;
  logic [3:0] n;
  initial begin
    rxd = 1'h1;
    external_transfer_clock_pin = 1'h0;
    busy = 1'h0;
  end
  // The line rests high on its pull-up and the clock stands low between frames.
  always @(posedge pclk) begin
    if (go && !busy) begin
      busy <= 1'h1;
      frame = 12'hfff;
      frame[0] = 1'h0;
      for (int i = 0; i < nbits; i++) frame[i + 1] = data[i];
      n = nbits + 4'h1;
      // Even parity keeps the count of ones even; the odd type inverts it.
      if (par_en) begin
        frame[n] = ^(data & ((9'h1 << nbits) - 9'h1)) ^ par_odd ^ par_bad;
        n = n + 4'h1;
      end
      frame[n] = !stop_bad;
      for (int k = 0; k <= n; k++) begin
        rxd <= frame[k];
        repeat (bit_len / 2) @(posedge pclk);
        external_transfer_clock_pin <= sync_mode;
        repeat (bit_len / 2) @(posedge pclk);
        external_transfer_clock_pin <= 1'h0;
      end
      rxd <= 1'h1;
      busy <= 1'h0;
    end
  end
endmodule
`default_nettype wire
